// ===== verilog/acsr_status_regs.sv
// Purpose: Read-only status register bank of a stepper positioning unit
// Assumes: Live status and position arrive synchronous to clock
// Notes:   Word and single-bit reads, one cycle to answer, writes refused with an error
//
// Operation
// R01: Device status bit 15 is one while emergency stop is in effect.
// R02: Device status bit 14 is one while reduced safety speed applies.
// R03: Device status bit 13 is one once the controller is ready.
// R04: Device status bit 12 is one while servo is on and ready.
// R05: Device status bit 11 flags push-and-hold ending without contact.
// R06: Bit 10 flags major alarm, bit 9 flags minor alarm.
// R07: Device status bit 5 is one while pause is applied.
// R08: Bit 4 shows homing complete, bit 3 shows positioning complete.
// R09: Extended status bit 11 during homing, bit 10 during push-and-hold.
// R10: Extended status bit 5 is one during any motion.
// R11: Zone bit 8 set while table_zone_valid is high and position is inside the table zone.
// R12: Zone bit 1 set while position is inside boundary two.
// R13: Zone bit 0 set while position is inside boundary one.
// R14: Completed position number sits in bits 5 to 0 unsigned.
// R15: Current position is signed 32-bit, high then low word.
// R16: Unassigned status bits always read zero.
// R17: All words are read-only and refreshed every cycle with clk_en high; the completed position number word only updates when position_done is set.
`timescale 1ns/1ps

module acsr_status_regs #(
  parameter int POS_W = 32
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire acsr_pkg::acsr_live_t  live,
  input  wire logic signed [POS_W-1:0] current_position,
  input  wire logic [acsr_pkg::DONE_INDEX_W-1:0] done_index,
  input  wire logic                  table_zone_valid,
  input  wire acsr_pkg::acsr_window_t table_zone,
  input  wire acsr_pkg::acsr_window_t boundary_one,
  input  wire acsr_pkg::acsr_window_t boundary_two,
  input  wire acsr_pkg::acsr_req_t   req,
  output logic                       rsp_valid,
  output logic [15:0]                rsp_data,
  output logic                       rsp_error
);

  // ----------------------------------------------------------------
  // Zone comparison
  // ----------------------------------------------------------------
  function automatic logic in_window(input logic signed [31:0] pos,
                                     input acsr_pkg::acsr_window_t w);
    in_window = (pos >= w.lower) && (pos <= w.upper);
  endfunction : in_window

  // ----------------------------------------------------------------
  // Live status words
  // ----------------------------------------------------------------
  logic [15:0] device_status_r;
  logic [15:0] extended_device_status_r;
  logic [15:0] zone_flags_r;
  logic [15:0] completed_position_number_r;
  logic [31:0] current_position_r;
  logic [15:0] device_status_nxt;
  logic [15:0] extended_device_status_nxt;
  logic [15:0] zone_flags_nxt;
  logic signed [31:0] pos_ext;

  assign pos_ext = 32'(current_position);

  always_comb begin
    device_status_nxt = acsr_pkg::WORD_ZERO;                            // [R16]
    device_status_nxt[acsr_pkg::DS_ESTOP]       = live.estop_active;   // [R01]
    device_status_nxt[acsr_pkg::DS_REDUCED]     = live.reduced_speed_active; // [R02]
    device_status_nxt[acsr_pkg::DS_CTRL_READY]  = live.controller_ready;     // [R03]
    device_status_nxt[acsr_pkg::DS_SERVO_READY] = live.servo_ready;    // [R04]
    device_status_nxt[acsr_pkg::DS_PRESS_MISS]  = live.press_miss;     // [R05]
    device_status_nxt[acsr_pkg::DS_MAJOR_ALARM] = live.major_alarm;    // [R06]
    device_status_nxt[acsr_pkg::DS_MINOR_ALARM] = live.minor_alarm;    // [R06]
    device_status_nxt[acsr_pkg::DS_PAUSE]       = live.pause_active;   // [R07]
    device_status_nxt[acsr_pkg::DS_HOMING_DONE] = live.homing_done;    // [R08]
    device_status_nxt[acsr_pkg::DS_POS_DONE]    = live.position_done;  // [R08]
  end

  always_comb begin
    extended_device_status_nxt = acsr_pkg::WORD_ZERO;                  // [R16]
    extended_device_status_nxt[acsr_pkg::XS_HOMING] = live.homing_active; // [R09]
    extended_device_status_nxt[acsr_pkg::XS_PUSH]   = live.push_active;   // [R09]
    // Homing and pushing count as motion even if the mover input lags
    extended_device_status_nxt[acsr_pkg::XS_MOVING] =
      live.moving | live.homing_active | live.push_active;             // [R10]
  end

  always_comb begin
    zone_flags_nxt = acsr_pkg::WORD_ZERO;                              // [R16]
    zone_flags_nxt[acsr_pkg::ZF_TABLE] =
      table_zone_valid & in_window(pos_ext, table_zone);               // [R11]
    zone_flags_nxt[acsr_pkg::ZF_BOUNDARY_TWO] = in_window(pos_ext, boundary_two); // [R12]
    zone_flags_nxt[acsr_pkg::ZF_BOUNDARY_ONE] = in_window(pos_ext, boundary_one); // [R13]
  end

  // ----------------------------------------------------------------
  // Refresh every enabled cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      device_status_r          <= acsr_pkg::WORD_ZERO;
      extended_device_status_r <= acsr_pkg::WORD_ZERO;
      zone_flags_r             <= acsr_pkg::WORD_ZERO;
      current_position_r       <= {acsr_pkg::WORD_ZERO, acsr_pkg::WORD_ZERO};
    end else if (clk_en) begin
      device_status_r          <= device_status_nxt;                  // [R17]
      extended_device_status_r <= extended_device_status_nxt;         // [R17]
      zone_flags_r             <= zone_flags_nxt;                     // [R17]
      current_position_r       <= pos_ext;                            // [R15]
    end
  end

  // Index captured only when a move completes, so it survives the next move
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      completed_position_number_r <= acsr_pkg::WORD_ZERO;
    end else if (clk_en && live.position_done) begin
      completed_position_number_r <=
        {{(16-acsr_pkg::DONE_INDEX_W){1'b0}}, done_index};            // [R14]
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  logic [15:0] word_sel;
  logic        word_hit;
  logic        bit_sel;
  logic        bit_hit;
  logic [15:0] bit_off;

  always_comb begin
    word_hit = 1'b1;
    case (req.addr)
      acsr_pkg::ADDR_DEVICE_STATUS: word_sel = device_status_r;
      acsr_pkg::ADDR_EXT_STATUS:    word_sel = extended_device_status_r;
      acsr_pkg::ADDR_ZONE_FLAGS:    word_sel = zone_flags_r;
      acsr_pkg::ADDR_DONE_POSITION: word_sel = completed_position_number_r;
      acsr_pkg::ADDR_POSITION_HIGH: word_sel = current_position_r[31:16]; // [R15]
      acsr_pkg::ADDR_POSITION_LOW:  word_sel = current_position_r[15:0];  // [R15]
      default: begin
        word_sel = acsr_pkg::WORD_ZERO;
        word_hit = 1'b0;
      end
    endcase
  end

  // Single bits map to the same words; gaps in the ranges are unmapped
  always_comb begin
    bit_sel = 1'b0;
    bit_hit = 1'b1;
    bit_off = acsr_pkg::WORD_ZERO;
    if (req.addr >= acsr_pkg::BIT_ESTOP && req.addr <= acsr_pkg::BIT_CTRL_LAST) begin
      bit_off = req.addr - acsr_pkg::BIT_ESTOP;
      bit_sel = device_status_r[4'(acsr_pkg::DS_ESTOP) - bit_off[3:0]];
    end else if (req.addr >= acsr_pkg::BIT_PAUSE && req.addr <= acsr_pkg::BIT_POS_DONE) begin
      bit_off = req.addr - acsr_pkg::BIT_PAUSE;
      bit_sel = device_status_r[4'(acsr_pkg::DS_PAUSE) - bit_off[3:0]];
    end else if (req.addr >= acsr_pkg::BIT_INDEX_TOP && req.addr <= acsr_pkg::BIT_INDEX_LOW) begin
      bit_off = req.addr - acsr_pkg::BIT_INDEX_TOP;
      bit_sel = completed_position_number_r[4'(acsr_pkg::DONE_INDEX_W - 1) - bit_off[3:0]];
    end else begin
      case (req.addr)
        acsr_pkg::BIT_PUSH:       bit_sel = extended_device_status_r[acsr_pkg::XS_PUSH];
        acsr_pkg::BIT_HOMING:     bit_sel = extended_device_status_r[acsr_pkg::XS_HOMING];
        acsr_pkg::BIT_MOVING:     bit_sel = extended_device_status_r[acsr_pkg::XS_MOVING];
        acsr_pkg::BIT_ZONE_TABLE: bit_sel = zone_flags_r[acsr_pkg::ZF_TABLE];
        acsr_pkg::BIT_ZONE_TWO:   bit_sel = zone_flags_r[acsr_pkg::ZF_BOUNDARY_TWO];
        acsr_pkg::BIT_ZONE_ONE:   bit_sel = zone_flags_r[acsr_pkg::ZF_BOUNDARY_ONE];
        default:                  bit_hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Answer, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= acsr_pkg::WORD_ZERO;
      rsp_error <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= req.valid;
      if (req.valid) begin
        // Writes change nothing and are refused
        if (req.write) begin                                           // [R17]
          rsp_data  <= acsr_pkg::WORD_ZERO;
          rsp_error <= 1'b1;
        end else if (req.bit_access) begin
          rsp_data  <= {15'h0000, bit_sel & bit_hit};
          rsp_error <= ~bit_hit;
        end else begin
          rsp_data  <= word_sel;
          rsp_error <= ~word_hit;
        end
      end
    end
  end

endmodule : acsr_status_regs

// ===== inc/acsr_pkg.sv
// Purpose: Constants and types for the actuator status register bank
// Assumes: Word addresses as seen by the serial link, 16-bit registers
// Notes:   Zone word offset is not fixed by the host protocol map
package acsr_pkg;

  // ----------------------------------------------------------------
  // Word addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_DEVICE_STATUS   = 16'h9005;
  localparam logic [15:0] ADDR_EXT_STATUS      = 16'h9007;
  localparam logic [15:0] ADDR_ZONE_FLAGS      = 16'h9008;
  localparam logic [15:0] ADDR_DONE_POSITION   = 16'h9014;
  localparam logic [15:0] ADDR_POSITION_HIGH   = 16'h9900;
  localparam logic [15:0] ADDR_POSITION_LOW    = 16'h9901;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DS_ESTOP        = 15;
  localparam int DS_REDUCED      = 14;
  localparam int DS_CTRL_READY   = 13;
  localparam int DS_SERVO_READY  = 12;
  localparam int DS_PRESS_MISS   = 11;
  localparam int DS_MAJOR_ALARM  = 10;
  localparam int DS_MINOR_ALARM  = 9;
  localparam int DS_PAUSE        = 5;
  localparam int DS_HOMING_DONE  = 4;
  localparam int DS_POS_DONE     = 3;
  localparam int XS_HOMING       = 11;
  localparam int XS_PUSH         = 10;
  localparam int XS_MOVING       = 5;
  localparam int ZF_TABLE        = 8;
  localparam int ZF_BOUNDARY_TWO = 1;
  localparam int ZF_BOUNDARY_ONE = 0;
  localparam int DONE_INDEX_W    = 6;

  // ----------------------------------------------------------------
  // Single-bit addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] BIT_ESTOP        = 16'h0100;
  localparam logic [15:0] BIT_CTRL_LAST    = 16'h0106;
  localparam logic [15:0] BIT_PAUSE        = 16'h010a;
  localparam logic [15:0] BIT_POS_DONE     = 16'h010c;
  localparam logic [15:0] BIT_PUSH         = 16'h0123;
  localparam logic [15:0] BIT_HOMING       = 16'h0124;
  localparam logic [15:0] BIT_MOVING       = 16'h012a;
  localparam logic [15:0] BIT_INDEX_TOP    = 16'h013a;
  localparam logic [15:0] BIT_INDEX_LOW    = 16'h013f;
  localparam logic [15:0] BIT_ZONE_TABLE   = 16'h0147;
  localparam logic [15:0] BIT_ZONE_TWO     = 16'h014e;
  localparam logic [15:0] BIT_ZONE_ONE     = 16'h014f;

  localparam logic [15:0] WORD_ZERO        = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic estop_active;
    logic reduced_speed_active;
    logic controller_ready;
    logic servo_ready;
    logic press_miss;
    logic major_alarm;
    logic minor_alarm;
    logic pause_active;
    logic homing_done;
    logic position_done;
    logic homing_active;
    logic push_active;
    logic moving;
  } acsr_live_t;

  typedef struct packed {
    logic signed [31:0] lower;
    logic signed [31:0] upper;
  } acsr_window_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        bit_access;
    logic [15:0] addr;
  } acsr_req_t;

endpackage : acsr_pkg

// ===== verif/acsr_status_regs_sva.sv
// Purpose: Port-level checks of the status register bank
// Assumes: Inputs steady two cycles and block enabled one cycle before a read
// Notes:   Expected words rebuilt from the live flags, not from the design
`timescale 1ns/1ps
module acsr_status_regs_chk #(
  parameter int POS_W = 32
) (
  input wire logic                       clock,
  input wire logic                       sys_rst,
  input wire logic                       clk_en,
  input wire acsr_pkg::acsr_live_t       live,
  input wire logic signed [POS_W-1:0]    current_position,
  input wire logic [5:0]                 done_index,
  input wire logic                       table_zone_valid,
  input wire acsr_pkg::acsr_window_t     table_zone,
  input wire acsr_pkg::acsr_window_t     boundary_one,
  input wire acsr_pkg::acsr_window_t     boundary_two,
  input wire acsr_pkg::acsr_req_t        req,
  input wire logic                       rsp_valid,
  input wire logic [15:0]                rsp_data,
  input wire logic                       rsp_error
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic in_one;
  assign in_one = boundary_one.lower <= current_position && current_position <= boundary_one.upper;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Steady inputs only: latency is one to two cycles
  sequence s_quiet;
    !$past(sys_rst) && !$past(sys_rst, 2) && $past(clk_en) && live == $past(live)
      && live == $past(live, 2) && current_position == $past(current_position)
      && current_position == $past(current_position, 2) && in_one == $past(in_one)
      && in_one == $past(in_one, 2);
  endsequence
  sequence s_rd(a);
    clk_en && req.valid && !req.write && !req.bit_access && req.addr == a;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_answer; clk_en && req.valid |=> rsp_valid; endproperty
  property p_idle; clk_en && !req.valid |=> !rsp_valid; endproperty
  property p_write; clk_en && req.valid && req.write |=> rsp_error && rsp_data == 16'h0000;
  endproperty
  property p_dev;
    s_quiet and s_rd(acsr_pkg::ADDR_DEVICE_STATUS) |=> !rsp_error
      && rsp_data == {$past(live[12:6]), 3'h0, $past(live[5:3]), 3'h0};
  endproperty
  property p_ext;
    s_quiet and s_rd(acsr_pkg::ADDR_EXT_STATUS) |=>
      rsp_data == {4'h0, $past(live[2:1]), 4'h0, $past(|live[2:0]), 5'h00};
  endproperty
  property p_hi; s_quiet and s_rd(acsr_pkg::ADDR_POSITION_HIGH) |=>
    rsp_data == $past(current_position[31:16]); endproperty
  property p_lo; s_quiet and s_rd(acsr_pkg::ADDR_POSITION_LOW) |=>
    rsp_data == $past(current_position[15:0]); endproperty
  property p_boundary_one_flag; s_quiet and s_rd(acsr_pkg::ADDR_ZONE_FLAGS) |=>
    rsp_data[0] == $past(in_one); endproperty
  a_answer: assert property (p_answer) else $error("read or write left unanswered");
  a_idle: assert property (p_idle) else $error("answer without a request");
  a_write: assert property (p_write) else $error("write not refused");
  a_dev: assert property (p_dev) else $error("device word wrong");
  a_ext: assert property (p_ext) else $error("extended word wrong");
  a_hi: assert property (p_hi) else $error("position high word wrong");
  a_lo: assert property (p_lo) else $error("position low word wrong");
  a_boundary_one_flag: assert property (p_boundary_one_flag) else $error("boundary one flag wrong");
endmodule : acsr_status_regs_chk

bind acsr_status_regs acsr_status_regs_chk #(.POS_W(POS_W)) acsr_status_regs_chk_inst (
  .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .live(live),
  .current_position(current_position), .done_index(done_index),
  .table_zone_valid(table_zone_valid), .table_zone(table_zone), .boundary_one(boundary_one),
  .boundary_two(boundary_two), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_error(rsp_error));

// ===== verif/acsr_plc_model.sv
// Purpose: Polling master on the far side of the register port
// Assumes: One request at a time, answer taken on the rising edge
// Notes:   Released address is scrambled so stale values cannot pass
`timescale 1ns/1ps
module acsr_plc_model (
  input  wire logic          clock,
  output acsr_pkg::acsr_req_t req,
  input  wire logic          rsp_valid,
  input  wire logic [15:0]   rsp_data,
  input  wire logic          rsp_error
);
  initial req = '0;
  task automatic xfer(input logic w, input logic b, input logic [15:0] a,
                      output logic [15:0] d, output logic e, output logic v);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{1'b1, w, b, a};
    @(posedge clock);
    req <= '{1'b0, ~w, ~b, ~a};
    // Answer taken at the rising edge that shows it, never half a cycle early
    do begin
      @(posedge clock);
      n++;
    end while (rsp_valid !== 1'b1 && n < 4);
    d = rsp_data;
    e = rsp_error;
    v = rsp_valid;
  endtask : xfer
endmodule : acsr_plc_model

// ===== verif/acsr_status_regs_test.sv
// Purpose: Directed regression of the status register bank
// Assumes: clk_en driven by the bench, words polled through the partner model
// Notes:   Every input change gets three cycles to reach the words
`timescale 1ns/1ps
module acsr_status_regs_test;
  logic                   clock = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   clk_en = 1'b1;
  acsr_pkg::acsr_live_t   live = '0;
  logic signed [31:0]     current_position = '0;
  logic [5:0]             done_index = '0;
  logic                   table_zone_valid = 1'b0;
  acsr_pkg::acsr_window_t table_zone = '0, boundary_one = '0, boundary_two = '0;
  acsr_pkg::acsr_req_t    req;
  logic                   rsp_valid, rsp_error, e, v;
  logic [15:0]            rsp_data, d;
  int                     n_errors = 0, checks = 0;
  always #12.5 clock = ~clock;
  acsr_status_regs acsr_status_regs_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .live(live), .current_position(current_position), .done_index(done_index),
    .table_zone_valid(table_zone_valid), .table_zone(table_zone), .boundary_one(boundary_one),
    .boundary_two(boundary_two), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error));
  acsr_plc_model acsr_plc_model_inst (.clock(clock), .req(req), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_error(rsp_error));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic b, input logic [15:0] a,
                     input logic [15:0] exp, input logic exp_err);
    acsr_plc_model_inst.xfer(w, b, a, d, e, v);
    chk({15'h0000, v}, {15'h0000, clk_en});
    chk(d, exp);
    chk({15'h0000, e}, {15'h0000, exp_err});
  endtask : acc
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask : settle
  task automatic stop_test();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // Bounded run: whole sequence needs well under 2000 cycles
  initial begin
    #50us;
    n_errors++;
    stop_test();
  end
  initial begin
    logic signed [31:0] zp [5] = '{32'h0000_000a, 32'hffff_fff6, 32'h0000_000b,
                                   32'h0000_001e, 32'h0000_0065};
    logic [15:0]        ze [5] = '{16'h0101, 16'h0101, 16'h0100, 16'h0102, 16'h0000};
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    // One flag at a time, so a swapped bit shows up
    for (int j = 0; j < 13; j++) begin
      live <= acsr_pkg::acsr_live_t'(13'h0001 << j);
      settle();
      acc(1'b0, 1'b0, 16'h9005, (j >= 6) ? 16'h1 << (j + 3) : (j >= 3) ? 16'h1 << j : 16'h0,
          1'b0);
      acc(1'b0, 1'b0, 16'h9007, (j < 3) ? 16'h0020 | ((j == 0) ? 16'h0 : 16'h1 << (j + 9))
          : 16'h0, 1'b0);
      if (j >= 6) acc(1'b0, 1'b1, 16'(16'h010c - j), 16'h0001, 1'b0);
    end
    $display("test flags done");
    done_index <= 6'h2a;
    live <= acsr_pkg::acsr_live_t'(13'h0008);
    settle();
    live <= '0;
    done_index <= 6'h15;
    settle();
    acc(1'b0, 1'b0, 16'h9014, 16'h002a, 1'b0);
    acc(1'b0, 1'b1, acsr_pkg::BIT_INDEX_LOW, 16'h0000, 1'b0);
    acc(1'b0, 1'b1, acsr_pkg::BIT_INDEX_TOP, 16'h0001, 1'b0);
    current_position <= 32'h8765_4321;
    settle();
    acc(1'b0, 1'b0, 16'h9900, 16'h8765, 1'b0);
    acc(1'b0, 1'b0, 16'h9901, 16'h4321, 1'b0);
    $display("test index and position done");
    boundary_one <= {32'hffff_fff6, 32'h0000_000a};
    boundary_two <= {32'h0000_0014, 32'h0000_001e};
    table_zone <= {32'hffff_ff9c, 32'h0000_0064};
    table_zone_valid <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      current_position <= zp[k];
      settle();
      acc(1'b0, 1'b0, acsr_pkg::ADDR_ZONE_FLAGS, ze[k], 1'b0);
    end
    acc(1'b0, 1'b1, acsr_pkg::BIT_ZONE_TABLE, 16'h0000, 1'b0);
    table_zone_valid <= 1'b0;
    current_position <= 32'h0000_0000;
    settle();
    acc(1'b0, 1'b0, acsr_pkg::ADDR_ZONE_FLAGS, 16'h0001, 1'b0);
    $display("test zones done");
    live <= acsr_pkg::acsr_live_t'(13'h1fff);
    acc(1'b1, 1'b0, 16'h9005, 16'h0000, 1'b1);
    acc(1'b0, 1'b0, 16'h9006, 16'h0000, 1'b1);
    settle();
    acc(1'b0, 1'b0, 16'h9005, 16'hfe38, 1'b0);
    $display("test access done");
    // Frozen block takes no request and keeps its last answer
    clk_en <= 1'b0;
    live <= '0;
    acc(1'b0, 1'b0, 16'h9005, 16'hfe38, 1'b0);
    clk_en <= 1'b1;
    settle();
    acc(1'b0, 1'b0, 16'h9005, 16'h0000, 1'b0);
    $display("test freeze done");
    stop_test();
  end
endmodule : acsr_status_regs_test
